//--- common/mlsa_pkg.sv
// Package for the load-immediate and store-accumulator decode/execute block.
// Assumes a 16-bit instruction word and a 12-bit data address space.
`default_nettype none

package mlsa_pkg;

    // ------------------------------------------------------------------
    // Opcode fields
    // ------------------------------------------------------------------
    localparam logic [7:0]  LOAD_IMM_OPC   = 8'h0E;
    localparam logic [6:0]  STORE_ACC_OPC  = 7'h37;
    localparam int          OPC_HI_POS     = 8;
    localparam int          BANK_BIT_POS   = 8;

    // ------------------------------------------------------------------
    // Addressing and reset constants
    // ------------------------------------------------------------------
    localparam logic [7:0]  INDEXED_LIMIT  = 8'h5F;
    localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;
    localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
    localparam logic [7:0]  ACC_RESET      = 8'h00;

    // ------------------------------------------------------------------
    // Quarter-phase sequencing
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MLSA_Q1 = 2'b00,
        MLSA_Q2 = 2'b01,
        MLSA_Q3 = 2'b10,
        MLSA_Q4 = 2'b11
    } mlsa_phase_t;

endpackage

`default_nettype wire

//--- verilog/mlsa_core.sv
// Decode and execute of load-immediate-to-accumulator and store-accumulator-to-file.
// Assumes the fetch unit presents one instruction word per four-phase cycle,
// captured at Q1, and that the data memory accepts a one-cycle write strobe.
`default_nettype none

// Functional notes
// RL1: Opcode high byte 0x0E loads the low-byte immediate into the accumulator, one cycle.
// RL2: Store opcode 0110 111a with a=0 targets the fixed access bank.
// RL3: With a=1 the address is bank select register value joined to file field.
// RL4: Extended set on, a=0, file field at most 95: indexed literal offset addressing.
// RL5: No status flag changes; store writes accumulator during Q4.
module mlsa_core (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [15:0] instr_i,
    input  wire logic [3:0]  bank_select_register_i,
    input  wire logic        ext_set_en_i,
    input  wire logic [11:0] index_base_i,
    output logic      [7:0]  accumulator_o,
    output logic      [11:0] wr_addr_o,
    output logic      [7:0]  wr_data_o,
    output logic             wr_en_o,
    output logic             indexed_mode_o,
    output logic      [1:0]  phase_o
);

    // ------------------------------------------------------------------
    // Local state
    // ------------------------------------------------------------------
    mlsa_pkg::mlsa_phase_t phase_q;
    mlsa_pkg::mlsa_phase_t phase_d;
    logic [15:0]           ir_q;
    logic [7:0]            acc_q;
    logic [7:0]            acc_d;
    logic [11:0]           addr_q;
    logic [11:0]           addr_d;
    logic                  wen_q;
    logic                  wen_d;
    logic                  idx_q;
    logic                  idx_d;

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    // The opcode tests feed several processes, so each lives in one place.
    function automatic logic f_is_load(input logic [15:0] word);
        f_is_load = (word[15:mlsa_pkg::OPC_HI_POS] == mlsa_pkg::LOAD_IMM_OPC);
    endfunction

    function automatic logic f_is_store(input logic [15:0] word);
        f_is_store = (word[15:mlsa_pkg::BANK_BIT_POS + 1] == mlsa_pkg::STORE_ACC_OPC);
    endfunction

    // Low access offsets land in bank zero and the rest in the top bank.
    function automatic logic [11:0] f_access_addr(input logic [7:0] offset);
        if (offset < mlsa_pkg::ACCESS_SPLIT) begin
            f_access_addr = {4'h0, offset};
        end else begin
            f_access_addr = {mlsa_pkg::ACCESS_HI_BANK, offset};
        end
    endfunction

    // ------------------------------------------------------------------
    // Phase sequencing
    // ------------------------------------------------------------------
    always_comb begin
        phase_d = mlsa_pkg::MLSA_Q1;
        unique case (phase_q)
            mlsa_pkg::MLSA_Q1: phase_d = mlsa_pkg::MLSA_Q2;
            mlsa_pkg::MLSA_Q2: phase_d = mlsa_pkg::MLSA_Q3;
            mlsa_pkg::MLSA_Q3: phase_d = mlsa_pkg::MLSA_Q4;
            mlsa_pkg::MLSA_Q4: phase_d = mlsa_pkg::MLSA_Q1;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            phase_q <= mlsa_pkg::MLSA_Q1;
        end else begin
            phase_q <= phase_d;
        end
    end

    // ------------------------------------------------------------------
    // Instruction latch
    // ------------------------------------------------------------------
    // The word is taken only in Q1, so the fetch side may move on afterwards.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ir_q <= 16'h0000;
        end else if (phase_q == mlsa_pkg::MLSA_Q1) begin
            ir_q <= instr_i;
        end
    end

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic        is_load;
    logic        is_store;
    logic        bank_bit;
    logic [7:0]  file_f;
    logic [11:0] tgt_addr;
    logic        use_idx;
    logic        in_q3;
    logic        in_q4;

    assign is_load  = f_is_load(ir_q);                                    // [RL1]
    assign is_store = f_is_store(ir_q);                                   // [RL2]
    assign bank_bit = ir_q[mlsa_pkg::BANK_BIT_POS];
    assign file_f   = ir_q[7:0];
    assign in_q3    = (phase_q == mlsa_pkg::MLSA_Q3);
    assign in_q4    = (phase_q == mlsa_pkg::MLSA_Q4);
    assign use_idx  = ext_set_en_i && !bank_bit
                      && (file_f <= mlsa_pkg::INDEXED_LIMIT);             // [RL4]

    // Indexed mode only replaces the low access half, never a banked access.
    always_comb begin
        tgt_addr = f_access_addr(file_f);                                 // [RL2]
        if (bank_bit) begin
            tgt_addr = {bank_select_register_i, file_f};                  // [RL3]
        end else if (use_idx) begin
            tgt_addr = index_base_i + {4'h0, file_f};                     // [RL4]
        end
    end

    // ------------------------------------------------------------------
    // Accumulator
    // ------------------------------------------------------------------
    // Accumulator is written in Q4, so a store in the following cycle sees it.
    always_comb begin
        acc_d = acc_q;
        if (in_q4 && is_load) begin
            acc_d = ir_q[7:0];                                            // [RL1]
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            acc_q <= mlsa_pkg::ACC_RESET;
        end else begin
            acc_q <= acc_d;
        end
    end

    // ------------------------------------------------------------------
    // Write strobe
    // ------------------------------------------------------------------
    // No flags exist in this block, so neither instruction can disturb them.
    assign wen_d = in_q3 && is_store;                                     // [RL5]

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wen_q <= 1'b0;
        end else begin
            wen_q <= wen_d;
        end
    end

    // ------------------------------------------------------------------
    // Store address and mode
    // ------------------------------------------------------------------
    // Both are held until the next store so the memory side may look late.
    always_comb begin
        addr_d = addr_q;
        idx_d  = idx_q;
        if (in_q3 && is_store) begin
            addr_d = tgt_addr;
            idx_d  = use_idx;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            addr_q <= 12'h000;
        end else begin
            addr_q <= addr_d;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            idx_q <= 1'b0;
        end else begin
            idx_q <= idx_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign accumulator_o  = acc_q;
    assign wr_addr_o      = addr_q;
    assign wr_data_o      = acc_q;                                        // [RL5]
    assign wr_en_o        = wen_q;
    assign indexed_mode_o = idx_q;
    assign phase_o        = phase_q;

endmodule

`default_nettype wire

//--- tb/mlsa_core_assertions.sv
// Checker for mlsa_core; needs only its ports.
`default_nettype none
module mlsa_chk (
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic        ext_set_en_i,
    input wire logic        wr_en_o,
    input wire logic        indexed_mode_o,
    input wire logic [15:0] instr_i,
    input wire logic [3:0]  bank_select_register_i,
    input wire logic [11:0] index_base_i,
    input wire logic [11:0] wr_addr_o,
    input wire logic [1:0]  phase_o,
    input wire logic [7:0]  accumulator_o,
    input wire logic [7:0]  wr_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    wire q1 = phase_o == 2'h0, ld = q1 && instr_i[15:8] == 8'h0e;
    wire st = q1 && instr_i[15:9] == 7'h37, sa = st && !instr_i[8];
    wire [7:0] f = instr_i[7:0];
    property p_ld; ld |-> ##4 accumulator_o == $past(f, 4); endproperty
    property p_wr; st |-> ##3 wr_en_o && wr_data_o == accumulator_o; endproperty
    property p_bk; st && instr_i[8] |-> ##3
        wr_addr_o == {$past(bank_select_register_i), $past(f, 3)}; endproperty
    property p_ac; sa ##3 !$past(ext_set_en_i) |-> wr_addr_o ==
        {($past(f, 3) < 8'h60) ? 4'h0 : 4'hf, $past(f, 3)}; endproperty
    property p_we; wr_en_o |-> phase_o == 2'h3 && $past(phase_o) == 2'h2; endproperty
    property p_ix; sa && f < 8'h60 ##3 $past(ext_set_en_i) |-> indexed_mode_o &&
        wr_addr_o == $past(index_base_i) + $past(f, 3); endproperty
    a_ld: assert property (p_ld) else $error("load");
    a_ac: assert property (p_ac) else $error("access");
    a_bk: assert property (p_bk) else $error("bank");
    a_ix: assert property (p_ix) else $error("index");
    a_wr: assert property (p_wr) else $error("write");
    a_we: assert property (p_we) else $error("strobe phase");
    c_ld: cover property (ld);
    c_st: cover property (st);
    c_ix: cover property (indexed_mode_o);
endmodule
bind mlsa_core mlsa_chk u_mlsa_chk (
    .clk_i                  (clk_i),
    .sys_rst_i              (sys_rst_i),
    .ext_set_en_i           (ext_set_en_i),
    .wr_en_o                (wr_en_o),
    .indexed_mode_o         (indexed_mode_o),
    .instr_i                (instr_i),
    .bank_select_register_i (bank_select_register_i),
    .index_base_i           (index_base_i),
    .wr_addr_o              (wr_addr_o),
    .phase_o                (phase_o),
    .accumulator_o          (accumulator_o),
    .wr_data_o              (wr_data_o)
);
`default_nettype wire

//--- tb/testbench.sv
// Bench for mlsa_core; no model beside it.
`default_nettype none
module testbench;
    timeunit 1ns; timeprecision 1ps;
    logic clk_i = 0, sys_rst_i = 1, ext_set_en_i = 0, wr_en_o, indexed_mode_o;
    logic [15:0] instr_i = 16'h0000;
    logic [11:0] index_base_i = 12'h100, wr_addr_o;
    logic [7:0] accumulator_o, wr_data_o;
    logic [3:0] bank_select_register_i = 4'h3;
    logic [1:0] phase_o;
    int error_cnt = 0, n_tests = 0;
    mlsa_core u_mlsa_core (
        .clk_i                  (clk_i),
        .sys_rst_i              (sys_rst_i),
        .instr_i                (instr_i),
        .bank_select_register_i (bank_select_register_i),
        .ext_set_en_i           (ext_set_en_i),
        .index_base_i           (index_base_i),
        .accumulator_o          (accumulator_o),
        .wr_addr_o              (wr_addr_o),
        .wr_data_o              (wr_data_o),
        .wr_en_o                (wr_en_o),
        .indexed_mode_o         (indexed_mode_o),
        .phase_o                (phase_o)
    );
    initial forever #2 clk_i = ~clk_i;
    initial begin repeat (900) @(posedge clk_i); error_cnt++; results(); end
    task chk(string n, logic [11:0] x, y);
        n_tests++;
        error_cnt += (y !== x);
        if (y !== x) $display("BAD %s exp %h got %h", n, x, y);
    endtask
    task op(logic [15:0] i, logic [11:0] a, logic s, logic x, logic [7:0] k,
            logic e = 1'b0, logic [3:0] b = 4'h3);
        while (phase_o !== 2'h0) @(negedge clk_i);
        {instr_i, bank_select_register_i, ext_set_en_i} = {i, b, e};
        repeat (3) @(negedge clk_i);
        chk("addr", a, wr_addr_o);
        chk("wr_en", {11'h000, s}, {11'h000, wr_en_o});
        chk("indexed", {11'h000, x}, {11'h000, indexed_mode_o});
        if (s) chk("wr_data", {4'h0, k}, {4'h0, wr_data_o});
        @(negedge clk_i);
        chk("acc", {4'h0, k}, {4'h0, accumulator_o});
        chk("wr_en_end", 12'h000, {11'h000, wr_en_o});
    endtask
    task t_moves();
        op(16'h0e5a, 12'h000, 1'b0, 1'b0, 8'h5a);
        op(16'h0d33, 12'h000, 1'b0, 1'b0, 8'h5a);
        op(16'h6e10, 12'h010, 1'b1, 1'b0, 8'h5a);
        op(16'h6ea0, 12'hfa0, 1'b1, 1'b0, 8'h5a);
        op(16'h6e5f, 12'h15f, 1'b1, 1'b1, 8'h5a, 1'b1);
        op(16'h6e60, 12'hf60, 1'b1, 1'b0, 8'h5a, 1'b1);
        op(16'h6f33, 12'h733, 1'b1, 1'b0, 8'h5a, 1'b1, 4'h7);
    endtask
    task t_reset();
        sys_rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        chk("acc_rst", 12'h000, {4'h0, accumulator_o});
        chk("addr_rst", 12'h000, wr_addr_o);
        chk("phase_rst", 12'h000, {10'h000, phase_o});
        sys_rst_i = 1'b0;
        op(16'h0ea5, 12'h000, 1'b0, 1'b0, 8'ha5);
        op(16'h6e20, 12'h020, 1'b1, 1'b0, 8'ha5);
    endtask
    task results();
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clk_i);
        sys_rst_i = 1'b0;
        t_moves();
        t_reset();
        results();
    end
endmodule
`default_nettype wire
